// ### src/clm_defs.svh
// constants for the configuration lock and checksum monitor
`ifndef CLM_DEFS_SVH
`define CLM_DEFS_SVH
`define CLM_WORD_W 24
`define CLM_ADDR_W 5
`define CLM_FIRST_ADDR 5'h09
`define CLM_KEY_ADDR 5'h1f
`define CLM_STATUS_ADDR 5'h0c
`define CLM_NUM_WORDS 23
`define CLM_PASSWORD 8'ha5
`define CLM_KEY_RESET 8'ha5
`define CLM_KEY_LSB 0
`define CLM_KEY_W 8
`define CLM_CHK_LSB 8
`define CLM_CHK_W 16
`define CLM_FLAGS_LSB 0
`define CLM_FLAGS_W 8
`define CLM_EN_INT_BIT 16
`define CLM_CFG_RESET 24'h000000
`define CLM_CRC_POLY 16'h8005
`define CLM_CRC_INIT 16'h0000
`define CLM_PASS_PERIODS 25
`define CLM_CNT_W 5
`endif

// ### src/clm_pkg.sv
// types shared by the configuration lock and checksum monitor
`include "clm_defs.svh"
package clm_pkg;
  typedef struct packed {
    logic en;
    logic [`CLM_ADDR_W-1:0] addr;
    logic [`CLM_WORD_W-1:0] data;
  } clm_wr_t;

  typedef enum logic [1:0] {
    CLM_PASS_IDLE = 2'b00,
    CLM_PASS_WAIT = 2'b01,
    CLM_PASS_FEED = 2'b10,
    CLM_PASS_DONE = 2'b11
  } clm_pass_t;
endpackage : clm_pkg

// ### src/clm_crc_engine.sv
// checksum pass sequencer and crc datapath on the modulator clock
`timescale 1ns/1ps
`default_nettype none
`include "clm_defs.svh"
module clm_crc_engine import clm_pkg::*; #(
  parameter int NUM_WORDS = `CLM_NUM_WORDS,
  parameter int PASS_PERIODS = `CLM_PASS_PERIODS
) (
  input wire logic modulator_clock,
  input wire logic rst_m,
  input wire logic run,
  input wire logic [NUM_WORDS*`CLM_WORD_W-1:0] snap_data,
  input wire logic snap_ack_tgl,
  output logic snap_req_tgl,
  output logic [`CLM_CHK_W-1:0] result,
  output logic result_strobe
);
  localparam int W = `CLM_WORD_W;
  localparam int IDX_W = $clog2(NUM_WORDS + 2);

  // one 24-bit word, msb first
  function automatic logic [`CLM_CHK_W-1:0] clm_crc_word(
    input logic [`CLM_CHK_W-1:0] c_in,
    input logic [W-1:0] w
  );
    logic [`CLM_CHK_W-1:0] c;
    c = c_in;
    for (int b = W - 1; b >= 0; b--) begin
      c = {c[`CLM_CHK_W-2:0], 1'b0} ^ ((c[`CLM_CHK_W-1] ^ w[b]) ? `CLM_CRC_POLY : '0);
    end
    return c;
  endfunction : clm_crc_word

  clm_pass_t state;
  logic [`CLM_CNT_W-1:0] pass_cnt;
  logic [IDX_W-1:0] idx;
  logic [`CLM_CHK_W-1:0] crc;
  logic ack_q1, ack_q2, ack_seen;

  wire logic has_b = (int'(idx) + 1) < NUM_WORDS;
  wire logic [IDX_W-1:0] idx_b = has_b ? idx + IDX_W'(1) : idx;
  wire logic [W-1:0] word_a = snap_data[idx*W +: W];
  wire logic [W-1:0] word_b = snap_data[idx_b*W +: W];
  wire logic [`CLM_CHK_W-1:0] crc_a = clm_crc_word(crc, word_a);
  wire logic [`CLM_CHK_W-1:0] crc_b = has_b ? clm_crc_word(crc_a, word_b) : crc_a;
  wire logic last_feed = (int'(idx) + 2) >= NUM_WORDS;
  wire logic pass_end = pass_cnt == `CLM_CNT_W'(PASS_PERIODS - 1);
  wire logic ack_new = ack_q2 != ack_seen;

  always_ff @(posedge modulator_clock or posedge rst_m) begin
    if (rst_m) begin
      ack_q1 <= 1'b0;
      ack_q2 <= 1'b0;
    end else begin
      ack_q1 <= snap_ack_tgl;
      ack_q2 <= ack_q1;
    end
  end

  // two words per cycle keeps the feed well inside one pass window
  always_ff @(posedge modulator_clock or posedge rst_m) begin
    if (rst_m) begin
      state <= CLM_PASS_IDLE;
      pass_cnt <= '0;
      idx <= '0;
      crc <= `CLM_CRC_INIT;
      ack_seen <= 1'b0;
      snap_req_tgl <= 1'b0;
      result <= '0;
      result_strobe <= 1'b0;
    end else if (!run) begin
      state <= CLM_PASS_IDLE;
      pass_cnt <= '0;
      ack_seen <= ack_q2;
      result_strobe <= 1'b0;
    end else begin
      pass_cnt <= pass_end ? '0 : pass_cnt + `CLM_CNT_W'(1);
      result_strobe <= 1'b0;
      unique case (state)
        CLM_PASS_IDLE: begin
          snap_req_tgl <= ~snap_req_tgl;
          state <= CLM_PASS_WAIT;
        end
        CLM_PASS_WAIT: begin
          if (ack_new) begin
            ack_seen <= ack_q2;
            crc <= `CLM_CRC_INIT;
            idx <= '0;
            state <= CLM_PASS_FEED;
          end
        end
        CLM_PASS_FEED: begin
          crc <= crc_b;
          idx <= idx + IDX_W'(2);
          if (last_feed) begin
            state <= CLM_PASS_DONE;
          end
        end
        CLM_PASS_DONE: begin
          if (pass_end) begin
            result <= crc;
            result_strobe <= 1'b1;
            state <= CLM_PASS_IDLE;
          end
        end
      endcase
    end
  end
endmodule : clm_crc_engine
`default_nettype wire

// ### src/clm_config_lock_crc_monitor.sv
// register map write lock, configuration checksum monitor and data-ready pin
`timescale 1ns/1ps
`default_nettype none
`include "clm_defs.svh"
module clm_config_lock_crc_monitor import clm_pkg::*; #(
  parameter int NUM_WORDS = `CLM_NUM_WORDS,
  parameter int PASS_PERIODS = `CLM_PASS_PERIODS,
  parameter logic [`CLM_WORD_W-1:0] CFG_RESET = `CLM_CFG_RESET
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic modulator_clock,
  input wire clm_wr_t wr,
  input wire logic [`CLM_ADDR_W-1:0] rd_addr,
  input wire logic [`CLM_FLAGS_W-1:0] channel_ready_flags,
  input wire logic conversion_done,
  output logic [`CLM_WORD_W-1:0] rd_data,
  output logic wr_accepted,
  output logic wr_discarded,
  output logic map_locked,
  output logic config_change_pending,
  output logic sample_ready_n
);
  localparam int W = `CLM_WORD_W;
  localparam int NUM_CFG = NUM_WORDS - 1;
  localparam int STATUS_IDX = int'(`CLM_STATUS_ADDR) - int'(`CLM_FIRST_ADDR);
  localparam logic [W-1:0] FLAGS_MASK =
    {{(W - `CLM_FLAGS_W){1'b0}}, {`CLM_FLAGS_W{1'b1}}} << `CLM_FLAGS_LSB;

  // ------------------------------------------------------------------
  // register side, clk domain
  // ------------------------------------------------------------------
  logic [W-1:0] cfg_mem [NUM_CFG];
  logic [`CLM_KEY_W-1:0] lock_key;
  logic [`CLM_CHK_W-1:0] config_checksum;
  logic [NUM_WORDS*W-1:0] snap;
  logic snap_fresh;
  logic snap_ack_tgl;
  logic write_since_snap;
  logic req_q1, req_q2, req_q3;
  logic res_q1, res_q2, res_q3;
  logic flag_q1, flag_q2;

  // modulator side signals read across the crossing
  logic snap_req_tgl;
  logic [`CLM_CHK_W-1:0] res_word;
  logic res_tgl;
  logic cfg_flag;

  wire logic unlocked = lock_key == `CLM_PASSWORD;
  wire logic wr_is_key = wr.addr == `CLM_KEY_ADDR;
  wire logic wr_in_cfg = (wr.addr >= `CLM_FIRST_ADDR) && (wr.addr < `CLM_KEY_ADDR);
  wire logic [`CLM_ADDR_W-1:0] wr_idx = wr.addr - `CLM_FIRST_ADDR;
  wire logic wr_cfg_ok = wr.en && wr_in_cfg && unlocked;
  wire logic wr_key_ok = wr.en && wr_is_key;
  wire logic wr_ok = wr_cfg_ok || wr_key_ok;
  wire logic new_req = req_q2 ^ req_q3;
  wire logic new_res = res_q2 ^ res_q3;
  wire logic en_int = cfg_mem[STATUS_IDX][`CLM_EN_INT_BIT];

  // per-entry storage for 0x09..0x1e; writes are committed at the bus edge
  genvar gi;
  generate
    for (gi = 0; gi < NUM_CFG; gi++) begin : g_cfg
      wire logic hit = wr_cfg_ok && (wr_idx == `CLM_ADDR_W'(gi));
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          cfg_mem[gi] <= CFG_RESET;
        end else if (hit) begin
          cfg_mem[gi] <= wr.data;
        end
      end
    end
  endgenerate

  // the key write itself is what moves the lock, so earlier burst words see
  // the old state and later ones the new
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lock_key <= `CLM_KEY_RESET;
    end else if (wr_key_ok) begin
      lock_key <= wr.data[`CLM_KEY_LSB +: `CLM_KEY_W];
    end
  end

  // message words in ascending address order
  logic [W-1:0] msg_word [NUM_WORDS];
  logic [NUM_WORDS*W-1:0] msg_flat;
  generate
    for (gi = 0; gi < NUM_CFG; gi++) begin : g_msg
      if (gi == STATUS_IDX) begin : g_status
        assign msg_word[gi] = cfg_mem[gi] | FLAGS_MASK;
      end else begin : g_plain
        assign msg_word[gi] = cfg_mem[gi];
      end
    end
    for (gi = 0; gi < NUM_WORDS; gi++) begin : g_flat
      assign msg_flat[gi*W +: W] = msg_word[gi];
    end
  endgenerate
  assign msg_word[NUM_WORDS-1] = {{`CLM_CHK_W{1'b0}}, lock_key};

  // toggles cross on two flops; the third only marks the edge
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      req_q1 <= 1'b0;
      req_q2 <= 1'b0;
      req_q3 <= 1'b0;
    end else begin
      req_q1 <= snap_req_tgl;
      req_q2 <= req_q1;
      req_q3 <= req_q2;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      res_q1 <= 1'b0;
      res_q2 <= 1'b0;
      res_q3 <= 1'b0;
    end else begin
      res_q1 <= res_tgl;
      res_q2 <= res_q1;
      res_q3 <= res_q2;
    end
  end

  // the alarm is a level, so two flops are enough
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flag_q1 <= 1'b0;
      flag_q2 <= 1'b0;
    end else begin
      flag_q1 <= cfg_flag;
      flag_q2 <= flag_q1;
    end
  end

  // snapshot handshake: held stable until the engine asks again, so the
  // modulator side may read it freely after seeing the ack toggle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      snap <= '0;
      snap_fresh <= 1'b1;
      snap_ack_tgl <= 1'b0;
    end else if (new_req) begin
      snap <= msg_flat;
      snap_fresh <= write_since_snap;
      snap_ack_tgl <= ~snap_ack_tgl;
    end
  end

  // a processed write re-arms the reference; set wins over the clear
  wire logic next_write_since_snap = wr_ok | (write_since_snap & ~new_req);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      write_since_snap <= 1'b1;
    end else begin
      write_since_snap <= next_write_since_snap;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      config_checksum <= '0;
    end else if (unlocked) begin
      config_checksum <= '0;
    end else if (new_res) begin
      config_checksum <= res_word;
    end
  end

  // read path: channel-ready flags are live, the checksum is read-only
  wire logic rd_in_cfg = (rd_addr >= `CLM_FIRST_ADDR) && (rd_addr < `CLM_KEY_ADDR);
  wire logic [`CLM_ADDR_W-1:0] rd_idx = rd_in_cfg ? rd_addr - `CLM_FIRST_ADDR : '0;
  wire logic rd_is_status = rd_addr == `CLM_STATUS_ADDR;
  wire logic [W-1:0] flags_word = W'(channel_ready_flags) << `CLM_FLAGS_LSB;
  wire logic [W-1:0] cfg_rd_word = rd_is_status ?
    ((cfg_mem[rd_idx] & ~FLAGS_MASK) | flags_word) : cfg_mem[rd_idx];
  wire logic [W-1:0] next_rd_data =
    (rd_addr == `CLM_KEY_ADDR) ? {config_checksum, lock_key} :
    rd_in_cfg ? cfg_rd_word : '0;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_data <= '0;
    end else begin
      rd_data <= next_rd_data;
    end
  end

  // every write word gets exactly one answer, one cycle after it was taken
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_accepted <= 1'b0;
      wr_discarded <= 1'b0;
    end else begin
      wr_accepted <= wr_ok;
      wr_discarded <= wr.en & ~wr_ok;
    end
  end

  // map_locked trails the key by one cycle, like every other clk-domain output
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      map_locked <= 1'b0;
      config_change_pending <= 1'b0;
    end else begin
      map_locked <= ~unlocked;
      config_change_pending <= flag_q2;
    end
  end

  // ------------------------------------------------------------------
  // modulator clock domain
  // ------------------------------------------------------------------
  logic rst_m_q1, rst_m;
  logic lock_q1, lock_m;
  logic en_q1, en_m;
  logic ref_valid;
  logic [`CLM_CHK_W-1:0] ref_crc;
  logic [`CLM_CHK_W-1:0] result;
  logic result_strobe;
  logic drp_rise, drp_fall;

  // reset asserts at once and releases on the modulator clock
  always_ff @(posedge modulator_clock or posedge rst) begin
    if (rst) begin
      rst_m_q1 <= 1'b1;
      rst_m <= 1'b1;
    end else begin
      rst_m_q1 <= 1'b0;
      rst_m <= rst_m_q1;
    end
  end

  always_ff @(posedge modulator_clock or posedge rst_m) begin
    if (rst_m) begin
      lock_q1 <= 1'b0;
      lock_m <= 1'b0;
      en_q1 <= 1'b0;
      en_m <= 1'b0;
    end else begin
      lock_q1 <= map_locked;
      lock_m <= lock_q1;
      en_q1 <= en_int;
      en_m <= en_q1;
    end
  end

  clm_crc_engine #(
    .NUM_WORDS(NUM_WORDS),
    .PASS_PERIODS(PASS_PERIODS)
  ) u_engine (
    .modulator_clock(modulator_clock),
    .rst_m(rst_m),
    .run(lock_m),
    .snap_data(snap),
    .snap_ack_tgl(snap_ack_tgl),
    .snap_req_tgl(snap_req_tgl),
    .result(result),
    .result_strobe(result_strobe)
  );

  // reference capture and mismatch flag
  wire logic take_ref = ~ref_valid | snap_fresh;
  wire logic mismatch = ref_valid & ~snap_fresh & (result != ref_crc);
  wire logic res_take = lock_m & result_strobe;

  // res_word is loaded on the same edge as its toggle and held long after, so it crosses whole
  always_ff @(posedge modulator_clock or posedge rst_m) begin
    if (rst_m) begin
      res_word <= '0;
      res_tgl <= 1'b0;
    end else if (res_take) begin
      res_word <= result;
      res_tgl <= ~res_tgl;
    end
  end

  always_ff @(posedge modulator_clock or posedge rst_m) begin
    if (rst_m) begin
      ref_valid <= 1'b0;
      ref_crc <= '0;
    end else if (!lock_m) begin
      ref_valid <= 1'b0;
    end else if (result_strobe && take_ref) begin
      ref_crc <= result;
      ref_valid <= 1'b1;
    end
  end

  // unlock is the only clear; a set needs the lock, so the two never meet
  always_ff @(posedge modulator_clock or posedge rst_m) begin
    if (rst_m) begin
      cfg_flag <= 1'b0;
    end else if (!lock_m) begin
      cfg_flag <= 1'b0;
    end else if (result_strobe && mismatch && en_m) begin
      cfg_flag <= 1'b1;
    end
  end

  // half-period pulse: low from the rising edge after a conversion until the
  // following falling edge; needs a flop on each edge
  always_ff @(posedge modulator_clock or posedge rst_m) begin
    if (rst_m) begin
      drp_rise <= 1'b0;
    end else if (conversion_done) begin
      drp_rise <= ~drp_rise;
    end
  end

  always_ff @(negedge modulator_clock or posedge rst_m) begin
    if (rst_m) begin
      drp_fall <= 1'b0;
    end else begin
      drp_fall <= drp_rise;
    end
  end

  // a gate of flops: a half-period pulse needs both edges, so no single flop can drive it
  assign sample_ready_n = ~(cfg_flag | (drp_rise ^ drp_fall));
endmodule : clm_config_lock_crc_monitor
`default_nettype wire

// ### sim/clm_host.sv
// host model: register write and read requests toward the monitor
`timescale 1ns/1ps
`default_nettype none
`include "clm_defs.svh"
module clm_host import clm_pkg::*; (
  input wire logic clk,
  input wire logic wr_accepted,
  input wire logic wr_discarded,
  input wire logic [`CLM_WORD_W-1:0] rd_data,
  output var clm_wr_t wr,
  output logic [`CLM_ADDR_W-1:0] rd_addr
);
  initial begin
    wr = '0;
    rd_addr = '0;
  end
  // one word per cycle so bursts run back to back; resp belongs to the previous word
  task automatic put(input logic en, input logic [`CLM_ADDR_W-1:0] a,
      input logic [`CLM_WORD_W-1:0] d, output logic [1:0] resp);
    @(posedge clk);
    #1;
    resp = {wr_accepted, wr_discarded};
    wr = '{en: en, addr: a, data: d};
  endtask : put
  task automatic get(input logic [`CLM_ADDR_W-1:0] a, output logic [`CLM_WORD_W-1:0] d);
    @(posedge clk);
    #1;
    rd_addr = a;
    @(posedge clk);
    #1;
    d = rd_data;
  endtask : get
endmodule : clm_host
`default_nettype wire

// ### sim/clm_monitor_props.sv
// port assertions for the lock and checksum monitor
`timescale 1ns/1ps
`default_nettype none
`include "clm_defs.svh"
module clm_monitor_props import clm_pkg::*; #(
  parameter int PASS_PERIODS = `CLM_PASS_PERIODS
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic modulator_clock,
  input wire clm_wr_t wr,
  input wire logic [`CLM_ADDR_W-1:0] rd_addr,
  input wire logic [`CLM_FLAGS_W-1:0] channel_ready_flags,
  input wire logic conversion_done,
  input wire logic [`CLM_WORD_W-1:0] rd_data,
  input wire logic wr_accepted,
  input wire logic wr_discarded,
  input wire logic map_locked,
  input wire logic config_change_pending,
  input wire logic sample_ready_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  wire logic key_wr = wr.en && wr.addr == `CLM_KEY_ADDR;
  wire logic cfg_wr = wr.en && wr.addr >= `CLM_FIRST_ADDR && !key_wr;
  logic key_locked;
  // lock state as the write port sees it, one cycle ahead of map_locked
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      key_locked <= 1'b0;
    end else if (key_wr) begin
      key_locked <= wr.data[7:0] != `CLM_PASSWORD;
    end
  end
  a_one_answer: assert property (wr.en |=> wr_accepted != wr_discarded)
    else $error("write answer not exactly one");
  a_open_accept: assert property (cfg_wr && !key_locked |=> wr_accepted)
    else $error("unlocked write dropped");
  a_locked_drop: assert property (cfg_wr && key_locked |=> wr_discarded)
    else $error("locked write stored");
  a_low_drop: assert property (wr.en && wr.addr < `CLM_FIRST_ADDR |=> wr_discarded)
    else $error("unmapped write stored");
  a_key_taken: assert property (key_wr |=> wr_accepted ##1
      map_locked == ($past(wr.data[7:0], 2) != `CLM_PASSWORD)) else $error("key write wrong");
  a_open_no_chk: assert property (!map_locked [*4] ##0 rd_addr == `CLM_KEY_ADDR
      |=> rd_data[23:8] == 16'h0) else $error("checksum not clear while unlocked");
  a_flag_drops: assert property (!map_locked [*8] |-> !config_change_pending)
    else $error("alarm kept while unlocked");
  a_flag_pin: assert property (config_change_pending && map_locked |-> !sample_ready_n)
    else $error("pin not held low by alarm");
  a_alarm_locked: assert property ($rose(config_change_pending) |-> map_locked)
    else $error("alarm raised while unlocked");
  c_locked_drop: cover property (cfg_wr && map_locked);
  c_lock: cover property ($rose(map_locked));
  c_unlock: cover property ($fell(map_locked));
endmodule : clm_monitor_props
bind clm_config_lock_crc_monitor clm_monitor_props #(.PASS_PERIODS(PASS_PERIODS)) i_props (
  .clk(clk), .rst(rst), .modulator_clock(modulator_clock), .wr(wr), .rd_addr(rd_addr),
  .channel_ready_flags(channel_ready_flags), .conversion_done(conversion_done),
  .rd_data(rd_data), .wr_accepted(wr_accepted), .wr_discarded(wr_discarded),
  .map_locked(map_locked), .config_change_pending(config_change_pending),
  .sample_ready_n(sample_ready_n));
`default_nettype wire

// ### sim/tb.sv
// self-checking bench for the lock and checksum monitor
`timescale 1ns/1ps
`default_nettype none
`include "clm_defs.svh"
module tb import clm_pkg::*; ;
  logic clk, rst, modulator_clock, conversion_done;
  logic [7:0] channel_ready_flags;
  clm_wr_t wr;
  logic [4:0] rd_addr;
  logic [23:0] rd_data, d;
  logic wr_accepted, wr_discarded, map_locked, config_change_pending, sample_ready_n;
  logic [1:0] resp;
  logic [31:0] seed;
  logic [23:0] mem [9:30];
  int n_errors = 0;
  int comparisons = 0;

  clm_config_lock_crc_monitor i_dut (.clk(clk), .rst(rst), .modulator_clock(modulator_clock),
    .wr(wr), .rd_addr(rd_addr), .channel_ready_flags(channel_ready_flags),
    .conversion_done(conversion_done), .rd_data(rd_data), .wr_accepted(wr_accepted),
    .wr_discarded(wr_discarded), .map_locked(map_locked),
    .config_change_pending(config_change_pending), .sample_ready_n(sample_ready_n));
  clm_host i_host (.clk(clk), .wr_accepted(wr_accepted), .wr_discarded(wr_discarded),
    .rd_data(rd_data), .wr(wr), .rd_addr(rd_addr));

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs
  // reference checksum over the bench's own copy of the map
  function automatic logic [15:0] crc_of(input logic [7:0] key);
    logic [15:0] c;
    logic [23:0] w;
    c = `CLM_CRC_INIT;
    for (int a = 9; a <= 31; a++) begin
      w = (a == 31) ? {16'h0, key} : mem[a];
      if (a == 12) w[7:0] = 8'hff;
      for (int b = 23; b >= 0; b--) begin
        c = {c[14:0], 1'b0} ^ (((c[15] ^ w[b]) == 1'b1) ? `CLM_CRC_POLY : 16'h0);
      end
    end
    return c;
  endfunction : crc_of
  task automatic chk(input string n, input logic [23:0] seen, input logic [23:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", n, exp, seen);
    end
  endtask : chk
  task automatic close_out();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : close_out

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // modulator clock runs free, phase unrelated to clk
  initial begin
    modulator_clock = 1'b0;
    #1.3;
    forever #3 modulator_clock = ~modulator_clock;
  end
  initial begin
    #50000;
    n_errors++;
    close_out();
  end

  initial begin
    rst = 1'b1;
    conversion_done = 1'b0;
    channel_ready_flags = 8'h00;
    seed = 32'h8cd20b14;
    repeat (5) @(posedge clk);
    #1;
    rst = 1'b0;
    i_host.get(5'h1f, d);
    chk("key_reset", d, {16'h0, `CLM_KEY_RESET});
    chk("lock_reset", {22'h0, map_locked, config_change_pending}, 24'h0);
    for (int a = 9; a <= 30; a++) begin
      seed = xs(seed);
      mem[a] = seed[23:0];
      if (a == 12) mem[a][16] = 1'b1;
      i_host.put(1'b1, a[4:0], mem[a], resp);
      if (a > 9) chk("burst_ack", {22'h0, resp}, 24'h2);
    end
    i_host.put(1'b1, 5'h1f, 24'h0, resp);
    chk("burst_ack", {22'h0, resp}, 24'h2);
    i_host.put(1'b1, 5'h10, 24'h123456, resp);
    chk("key_ack", {22'h0, resp}, 24'h2);
    i_host.put(1'b1, 5'h03, 24'h1, resp);
    chk("locked_drop", {22'h0, resp}, 24'h1);
    i_host.put(1'b0, 5'h00, 24'h0, resp);
    chk("unmapped_drop", {22'h0, resp}, 24'h1);
    chk("locked", {23'h0, map_locked}, 24'h1);
    // flags wander while locked; they must not disturb the checksum
    for (int a = 9; a <= 30; a++) begin
      seed = xs(seed);
      channel_ready_flags = seed[7:0];
      i_host.get(a[4:0], d);
      if (a == 12) begin
        chk("status", d & 24'h0100ff, {8'h01, 8'h0, channel_ready_flags});
      end else begin
        chk("readback", d, mem[a]);
      end
    end
    repeat (150) @(posedge clk);
    i_host.get(5'h1f, d);
    chk("checksum", d, {crc_of(8'h00), 8'h00});
    chk("no_alarm", {22'h0, config_change_pending, sample_ready_n}, 24'h1);
    i_host.put(1'b1, 5'h1f, 24'h000001, resp);
    i_host.put(1'b0, 5'h00, 24'h0, resp);
    chk("rekey_ack", {22'h0, resp}, 24'h2);
    repeat (150) @(posedge clk);
    i_host.get(5'h1f, d);
    chk("checksum_new", d, {crc_of(8'h01), 8'h01});
    @(posedge modulator_clock);
    #1;
    conversion_done = 1'b1;
    @(posedge modulator_clock);
    #1;
    conversion_done = 1'b0;
    chk("pin_low", {23'h0, sample_ready_n}, 24'h0);
    @(negedge modulator_clock);
    #1;
    chk("pin_high", {23'h0, sample_ready_n}, 24'h1);
    i_host.put(1'b1, 5'h1f, {16'h0, `CLM_PASSWORD}, resp);
    i_host.put(1'b0, 5'h00, 24'h0, resp);
    chk("unlock_ack", {22'h0, resp}, 24'h2);
    repeat (10) @(posedge clk);
    i_host.get(5'h1f, d);
    chk("unlocked_key", d, {16'h0, `CLM_PASSWORD});
    chk("unlocked", {22'h0, map_locked, config_change_pending}, 24'h0);
    close_out();
  end
endmodule : tb
`default_nettype wire
